// ==== inc/emb_memory_block_regs.vh ====
`ifndef EMB_MEMORY_BLOCK_REGS_VH
`define EMB_MEMORY_BLOCK_REGS_VH

// Shape codes: word width is 16 >> code
`define EMB_SHAPE_128X16 3'h0
`define EMB_SHAPE_256X8 3'h1
`define EMB_SHAPE_512X4 3'h2
`define EMB_SHAPE_1024X2 3'h3
`define EMB_SHAPE_2048X1 3'h4

// Array geometry, constant capacity of 2048 bits
`define EMB_ROW_W 16
`define EMB_ROWS 128
`define EMB_ROW_AW 7
`define EMB_ARRAY_AW 11
`define EMB_PAGE_W 2
`define EMB_ADDR_W 13

// Product-term section
`define EMB_OWN_TERMS 2
`define EMB_EXP_SETS 15
`define EMB_FEEDBACK_W 10

// Reset values
`define EMB_RD_DATA_RST 16'h0000
`define EMB_PAGE_RST 2'h0

`endif

// ==== logic/emb_memory_block.v ====
`timescale 1ns/100ps
`include "emb_memory_block_regs.vh"

// Operation
// - The array holds 2048 bits and is read and written as 128x16, 256x8, 512x4, 1024x2 or 2048x1.
// - The write strobe is made inside the block from the clock, so callers only meet clock setup and hold.
// - Two blocks sharing address and control with separate data lanes form one memory twice as wide.
// - One block serves up to 2048 words deep with no outside control logic and no extra latency.
// - For deeper memories each block drives a shared line only when its programmed page is addressed.
// - In a four-block 8192-word memory the low eleven address bits go to the array and the top two to the page decoder.
// - With page decoding on and distinct page ids, the output enable lets only the addressed block of a column drive the shared line.
// - Two clear sources come from global or local signals, may be inverted, and each macrocell picks one or none.
// - A macrocell OR takes its own two terms plus up to fifteen borrowed pairs, thirty-two terms in all.
// - Ten output lines, nine of them distinct, feed back to adjacent logic elements.
module emb_memory_block #(
  parameter NMC = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [2:0] shape_i,
  input wire [`EMB_ADDR_W-1:0] addr_i,
  input wire wr_en_i,
  input wire [`EMB_ROW_W-1:0] wr_data_i,
  output wire [`EMB_ROW_W-1:0] rd_data_o,
  input wire page_dec_en_i,
  input wire [`EMB_PAGE_W-1:0] page_id_i,
  output wire [`EMB_ROW_W-1:0] line_data_o,
  output wire line_oe_o,
  output wire [`EMB_FEEDBACK_W-1:0] feedback_o,
  input wire [1:0] clr_glb_i,
  input wire [1:0] clr_loc_i,
  input wire [1:0] clr_use_loc_i,
  input wire [1:0] clr_inv_i,
  input wire [2*NMC-1:0] clr_sel_i,
  input wire [`EMB_OWN_TERMS*NMC-1:0] pterm_i,
  input wire [`EMB_EXP_SETS*NMC-1:0] exp_mask_i,
  output wire [NMC-1:0] mc_q_o
);

  // ----------------------------------------------------------------
  // Shape decode
  // ----------------------------------------------------------------
  // Unknown shape codes fall back to 2048x1 so no write can land twice
  function [2:0] shape_clamp;
    input [2:0] s;
    begin
      if (s > `EMB_SHAPE_2048X1)
      begin
        shape_clamp = `EMB_SHAPE_2048X1;
      end
      else
      begin
        shape_clamp = s;
      end
    end
  endfunction

  // Log2 of the word width: 4 for 128x16 down to 0 for 2048x1
  function [2:0] lane_bits;
    input [2:0] s;
    begin
      lane_bits = 3'h4 - s;
    end
  endfunction

  // The shape code equals the number of lane-select address bits
  function [`EMB_ROW_AW-1:0] row_of;
    input [`EMB_ARRAY_AW-1:0] a;
    input [2:0] s;
    reg [`EMB_ARRAY_AW-1:0] t;
    begin
      t = a >> s;
      row_of = t[`EMB_ROW_AW-1:0];
    end
  endfunction

  function [3:0] lane_of;
    input [`EMB_ARRAY_AW-1:0] a;
    input [2:0] s;
    reg [3:0] m;
    begin
      m = 4'hf >> lane_bits(s);
      lane_of = a[3:0] & m;
    end
  endfunction

  wire [2:0] shape = shape_clamp(shape_i);
  wire [`EMB_ARRAY_AW-1:0] arr_addr = addr_i[`EMB_ARRAY_AW-1:0];
  wire [`EMB_PAGE_W-1:0] page_addr = addr_i[`EMB_ADDR_W-1:`EMB_ARRAY_AW];
  wire [`EMB_ROW_AW-1:0] row = row_of(arr_addr, shape);
  wire [3:0] lane = lane_of(arr_addr, shape);
  wire [2:0] lsh = lane_bits(shape);

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  // Contents are not reset; unwritten words read as unknown
  reg [`EMB_ROW_W-1:0] mem [0:`EMB_ROWS-1];
  reg [`EMB_ROW_W-1:0] wr_row;
  reg [`EMB_ROW_W-1:0] rd_word;
  reg [`EMB_ROW_W-1:0] cur_row;
  reg [4:0] wmask;
  integer b;

  // Narrow words sit side by side in a row, lane 0 at the bottom
  // Merge the written lane into the row; every lane uses the low data pins
  always @*
  begin
    cur_row = mem[row];
    wr_row = cur_row;
    rd_word = 16'h0000;
    wmask = 5'h10 >> shape;
    for (b = 0; b < `EMB_ROW_W; b = b + 1)
    begin
      if ((b >> lsh) == lane)
      begin
        wr_row[b] = wr_data_i[b & (wmask - 5'h01)];
      end
      if (b < wmask)
      begin
        rd_word[b] = cur_row[(lane << lsh) + b];
      end
    end
  end

  // Self-timed strobe: only the clock edge qualifies the write
  always @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[row] <= wr_row;
    end
  end

  // ----------------------------------------------------------------
  // Read port and page decoder
  // ----------------------------------------------------------------
  reg [`EMB_ROW_W-1:0] rd_data_q;
  reg [`EMB_PAGE_W-1:0] page_q;

  // Read returns the old word on a same-cycle write
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_q <= `EMB_RD_DATA_RST;
      page_q <= `EMB_PAGE_RST;
    end
    else
    begin
      rd_data_q <= rd_word;
      page_q <= page_addr;
    end
  end

  assign rd_data_o = rd_data_q;
  assign line_data_o = rd_data_q;
  // Page is registered with the data so the enable never leads the word.
  // Distinct page ids across a column give one driver per cycle.
  assign line_oe_o = ~page_dec_en_i | (page_q == page_id_i);
  // Bit 8 is repeated on the tenth line, so nine lines are distinct
  assign feedback_o = {rd_data_q[8], rd_data_q[8:0]};

  // ----------------------------------------------------------------
  // Product-term macrocells
  // ----------------------------------------------------------------
  // Either clear source comes from a global or a local line, then may be inverted
  function clr_pick;
    input glb;
    input loc;
    input use_loc;
    input inv;
    begin
      clr_pick = (use_loc ? loc : glb) ^ inv;
    end
  endfunction

  wire [1:0] clr_src;
  assign clr_src[0] = clr_pick(clr_glb_i[0], clr_loc_i[0],
    clr_use_loc_i[0], clr_inv_i[0]);
  assign clr_src[1] = clr_pick(clr_glb_i[1], clr_loc_i[1],
    clr_use_loc_i[1], clr_inv_i[1]);

  genvar i;
  generate
    for (i = 0; i < NMC; i = i + 1)
    begin : g_mc
      reg mc_q;
      reg sum_d;
      integer j;
      wire [1:0] sel = clr_sel_i[2*i+1:2*i];
      // Code 3 is treated as no clear
      wire mc_clr = sys_rst_i | (sel == 2'h1 & clr_src[0]) | (sel == 2'h2 & clr_src[1]);

      // Borrowed pairs come from the next fifteen macrocells, wrapping round
      always @*
      begin
        sum_d = |pterm_i[2*i+1:2*i];
        for (j = 0; j < `EMB_EXP_SETS; j = j + 1)
        begin
          if (exp_mask_i[`EMB_EXP_SETS*i+j])
          begin
            sum_d = sum_d | (|pterm_i[2*((i+1+j)%NMC)+:2]);
          end
        end
      end

      always @(posedge clk_i or posedge mc_clr)
      begin
        if (mc_clr)
        begin
          mc_q <= 1'b0;
        end
        else
        begin
          mc_q <= sum_d;
        end
      end

      assign mc_q_o[i] = mc_q;
    end
  endgenerate

endmodule

// ==== verification/emb_mb_assertions.sv ====
`timescale 1ns/100ps
module emb_mb_assertions #(
  parameter NMC = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [2:0] shape_i,
  input wire [12:0] addr_i,
  input wire wr_en_i,
  input wire [15:0] wr_data_i,
  input wire [15:0] rd_data_o,
  input wire page_dec_en_i,
  input wire [1:0] page_id_i,
  input wire [15:0] line_data_o,
  input wire line_oe_o,
  input wire [9:0] feedback_o,
  input wire [2*NMC-1:0] clr_sel_i,
  input wire [2*NMC-1:0] pterm_i,
  input wire [15*NMC-1:0] exp_mask_i,
  input wire [NMC-1:0] mc_q_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_zero: assert property (disable iff (1'b0)
    sys_rst_i |-> rd_data_o == 16'h0 && mc_q_o == 0) else $error("outputs set in reset");
  a_read_after_write: assert property ((wr_en_i && shape_i == 3'h0) ##1
    ($stable(addr_i) && shape_i == 3'h0 && !wr_en_i) |=> rd_data_o == $past(wr_data_i, 2))
    else $error("read data differs from write");
  a_narrow_upper: assert property ($past(shape_i) == 3'h4 && !$past(sys_rst_i)
    |-> rd_data_o[15:1] == 15'h0) else $error("upper bits set in one-bit shape");
  a_line_mirror: assert property (line_data_o == rd_data_o)
    else $error("line data differs from read data");
  a_oe_flat: assert property (!page_dec_en_i |-> line_oe_o)
    else $error("line released without page decoding");
  a_oe_page: assert property (page_dec_en_i && !$past(sys_rst_i)
    |-> line_oe_o == ($past(addr_i[12:11]) == page_id_i)) else $error("wrong page drives");
  a_feedback_dup: assert property (feedback_o == {rd_data_o[8], rd_data_o[8:0]})
    else $error("feedback lines wrong");
  a_mc_own: assert property ((clr_sel_i[1:0] == 2'h0 && exp_mask_i[14:0] == 15'h0)
    ##1 clr_sel_i[1:0] == 2'h0 |-> mc_q_o[0] == $past(|pterm_i[1:0]))
    else $error("macrocell term sum wrong");
endmodule
bind emb_memory_block emb_mb_assertions #(.NMC(NMC)) chk_u (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .shape_i(shape_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
  .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .page_dec_en_i(page_dec_en_i),
  .page_id_i(page_id_i), .line_data_o(line_data_o), .line_oe_o(line_oe_o),
  .feedback_o(feedback_o), .clr_sel_i(clr_sel_i), .pterm_i(pterm_i),
  .exp_mask_i(exp_mask_i), .mc_q_o(mc_q_o));

// ==== verification/emb_mb_column.sv ====
`timescale 1ns/100ps
module emb_mb_column (
  input wire clk_i,
  input wire line_oe_i,
  input wire [15:0] line_data_i,
  output wire [15:0] col_o
);
  reg [15:0] idle_q = 16'h5a5a;
  // Released line changes every cycle, so a stale value never passes
  always @(posedge clk_i) idle_q <= ~idle_q;
  assign col_o = line_oe_i ? line_data_i : idle_q;
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  reg clk_i = 0, sys_rst_i = 0, wr_en_i = 0, page_dec_en_i = 0;
  reg [2:0] shape_i = 0;
  reg [12:0] addr_i = 0;
  reg [15:0] wr_data_i = 0, wr_hi_i = 0;
  reg [1:0] page_id_i = 0, clr_glb_i = 0, clr_loc_i = 0, clr_use_loc_i = 0, clr_inv_i = 0;
  reg [31:0] clr_sel_i = 0, pterm_i = 0;
  reg [239:0] exp_mask_i = 0;
  wire [15:0] rd_data_o, line_data_o, col_w, mc_q_o, rd_hi_w;
  wire line_oe_o;
  wire [9:0] feedback_o;
  integer failures = 0, n_checks = 0, cyc = 0, i;
  always #2.5 clk_i = ~clk_i;
  emb_memory_block dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .shape_i(shape_i),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
    .page_dec_en_i(page_dec_en_i), .page_id_i(page_id_i), .line_data_o(line_data_o),
    .line_oe_o(line_oe_o), .feedback_o(feedback_o), .clr_glb_i(clr_glb_i),
    .clr_loc_i(clr_loc_i), .clr_use_loc_i(clr_use_loc_i), .clr_inv_i(clr_inv_i),
    .clr_sel_i(clr_sel_i), .pterm_i(pterm_i), .exp_mask_i(exp_mask_i), .mc_q_o(mc_q_o));
  emb_mb_column col_u (.clk_i(clk_i), .line_oe_i(line_oe_o), .line_data_i(line_data_o),
    .col_o(col_w));
  // Upper half of a 128x32 memory: same address and control, own data lanes
  emb_memory_block dut_hi_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .shape_i(shape_i),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_hi_i), .rd_data_o(rd_hi_w),
    .page_dec_en_i(page_dec_en_i), .page_id_i(page_id_i), .line_data_o(),
    .line_oe_o(), .feedback_o(), .clr_glb_i(clr_glb_i), .clr_loc_i(clr_loc_i),
    .clr_use_loc_i(clr_use_loc_i), .clr_inv_i(clr_inv_i), .clr_sel_i(clr_sel_i),
    .pterm_i(pterm_i), .exp_mask_i(exp_mask_i), .mc_q_o());
  task step; @(posedge clk_i); #1; endtask
  task wr(input [12:0] a, input [15:0] d);
    addr_i = a; wr_data_i = d; wr_en_i = 1; step; wr_en_i = 0;
  endtask
  task rd(input [12:0] a, input [15:0] e);
    addr_i = a; step; `CHK(rd_data_o, e)
  endtask
  task t_shapes;
    for (i = 0; i < 5; i++)
    begin
      shape_i = i; wr(13'h10, 16'h9ab7);
      rd(13'h10, 16'h9ab7 & (16'hffff >> (16 - (16 >> i))));
    end
    // Codes above 2048x1 act as 2048x1; an address in the top row of the 2048-word range
    shape_i = 7;
    wr(13'h7f1, 16'h0001);
    rd(13'h7f1, 16'h0001);
    shape_i = 0; wr(13'h3, 16'ha5c3); shape_i = 4;
    // Same bits seen one at a time: word 3 lands on one-bit addresses 48..63
    for (i = 0; i < 16; i++) rd(13'h30 + i, (16'ha5c3 >> i) & 16'h1);
    $display("t_shapes done");
  endtask
  task t_deep;
    shape_i = 0; page_dec_en_i = 1; page_id_i = 2; wr(13'h1005, 16'h1234);
    for (i = 0; i < 4; i++)
    begin
      rd({i[1:0], 11'h5}, 16'h1234);
      `CHK(line_oe_o, i == 2)
      if (i == 2) `CHK(col_w, 16'h1234)
    end
    `CHK(feedback_o, 10'h034)
    page_dec_en_i = 0; #1; `CHK(line_oe_o, 1'b1)
    step;
    $display("t_deep done");
  endtask
  task t_wide;
    shape_i = 0;
    wr_hi_i = 16'hbeef;
    wr(13'h20, 16'hcafe);
    rd(13'h20, 16'hcafe);
    `CHK(rd_hi_w, 16'hbeef)
    $display("t_wide done");
  endtask
  task t_mc;
    pterm_i[3:2] = 2'b10; step; step; `CHK(mc_q_o[1:0], 2'b10)
    exp_mask_i[0] = 1; step; `CHK(mc_q_o[1:0], 2'b11)
    exp_mask_i[0] = 0; exp_mask_i[14] = 1; pterm_i = 32'h40000000;
    step; `CHK(mc_q_o, 16'h8001)
    clr_sel_i[1:0] = 2'h1; clr_glb_i = 2'b01; #1; `CHK(mc_q_o, 16'h8000)
    step;
    clr_use_loc_i = 2'b01; step; `CHK(mc_q_o[0], 1'b1)
    clr_inv_i = 2'b01; #1; `CHK(mc_q_o[0], 1'b0)
    step;
    clr_sel_i[1:0] = 2'h2; step; `CHK(mc_q_o[0], 1'b1)
    // Select code 3 means no clear even with source 0 active
    clr_sel_i[1:0] = 2'h3;
    exp_mask_i[14] = 0;
    pterm_i = 32'h1;
    step;
    `CHK(mc_q_o, 16'h0001)
    clr_sel_i[1:0] = 2'h0;
    step;
    pterm_i = 32'h0;
    step;
    `CHK(mc_q_o, 16'h0000)
    $display("t_mc done");
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  initial
  begin
    // Raised after time zero so the asynchronous reset sees an edge
    #1 sys_rst_i = 1;
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 0;
    t_shapes;
    t_deep;
    t_wide;
    t_mc;
    tally_and_finish;
  end
endmodule
